// ==== rtl/irq_defs.svh ====
// Purpose: Offsets, field positions and reset values of the enable block
// Assumes: Registers are 24 bits wide, addressed by a 6-bit register index
// Notes: Definitions only
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH
`define REG_W 24
`define ADDR_W 6
`define OFS_COMP_EDGE_UPPER 6'h23
`define OFS_DIAG_ENABLE 6'h24
`define RST_COMP_EDGE_UPPER 24'h000000
`define RST_DIAG_ENABLE 24'h000000
`define DIAG_WRITABLE_MASK 24'h000fff
`define DIAG_SRC_W 12
`define EDGE_IN_FIRST 12
`define EDGE_IN_COUNT 12
`define EDGE_IN_LAST_USED 18
`define EDGE_FIELD_W 2
`define BIT_CONVERTER_ERR 11
`define BIT_WETTING_ERR 10
`define BIT_SUPPLY_B 9
`define BIT_SUPPLY_A 8
`define BIT_CHECKSUM_DONE 7
`define BIT_UNDERVOLTAGE 6
`define BIT_SUPPLY_HIGH 5
`define BIT_THERMAL_WARN 4
`define BIT_THERMAL_SHUT 3
`define BIT_SWITCH_CHANGE 2
`define BIT_PARITY_ERR 1
`define BIT_SERIAL_FAIL 0
`endif

// ==== rtl/irq_pkg.sv ====
// Purpose: Shared types of the enable block
// Assumes: Nothing beyond the constants header
// Notes: Edge codes are the two-bit field values
package irq_pkg;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_code_t;
endpackage

// ==== rtl/edge_detect.sv ====
// Purpose: Per-input crossing detector with edge-select code
// Assumes: cmp_i is a comparator result on clk_i, already synchronous
// Notes: First sample after reset compares against zero
`timescale 1ns/1ps
module edge_detect
  import irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmp_i,
  input wire logic [1:0] code_i,
  output logic hit_o
);
  logic prev;
  logic next_prev;
  logic rise;
  logic fall;

  always_comb begin
    next_prev = cmp_i;
    rise = cmp_i & ~prev;
    fall = ~cmp_i & prev;
    case (edge_code_t'(code_i))
      EDGE_NONE: hit_o = 1'b0;
      EDGE_RISE: hit_o = rise;
      EDGE_FALL: hit_o = fall;
      EDGE_BOTH: hit_o = rise | fall;
      default: hit_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end
endmodule

// ==== rtl/diag_gate.sv ====
// Purpose: Gates diagnostic event levels with their enable bits
// Assumes: Event inputs are pending levels from the status logic
// Notes: Purely combinational; the top registers the result
`timescale 1ns/1ps
`include "irq_defs.svh"
module diag_gate
  import irq_pkg::*;
(
  input wire logic [`DIAG_SRC_W-1:0] event_i,
  input wire logic [`DIAG_SRC_W-1:0] enable_i,
  output logic any_o
);
  logic [`DIAG_SRC_W-1:0] gated;

  always_comb begin
    gated = event_i & enable_i;
    any_o = |gated;
  end
endmodule

// ==== rtl/switch_irq_enable_mask.sv ====
// Purpose: Interrupt enables for comparator inputs 12-23 and diagnostics
// Assumes: Register access arrives as index, strobes and data on clk_i
// Notes: Interrupt pin is active low and driven from a flip-flop
`timescale 1ns/1ps
`include "irq_defs.svh"
module switch_irq_enable_mask
  import irq_pkg::*;
#(
  parameter int NUM_IN = `EDGE_IN_COUNT
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`REG_W-1:0] reg_wdata_i,
  output logic [`REG_W-1:0] reg_rdata_o,
  input wire logic [NUM_IN-1:0] cmp_result_i,
  input wire logic [`DIAG_SRC_W-1:0] diag_event_i,
  input wire logic [NUM_IN-1:0] comp_pending_clr_i,
  output logic [NUM_IN-1:0] comp_pending_o,
  output logic irq_n_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [`REG_W-1:0] comp_edge_irq_enable_upper;
  logic [`REG_W-1:0] diag_irq_enable;
  logic [`REG_W-1:0] next_comp_edge;
  logic [`REG_W-1:0] next_diag_en;
  logic [`REG_W-1:0] next_rdata;

  function automatic logic hit_addr(input logic [`ADDR_W-1:0] a,
                                    input logic [`ADDR_W-1:0] ofs);
    hit_addr = (a == ofs);
  endfunction

  always_comb begin
    next_comp_edge = comp_edge_irq_enable_upper;
    next_diag_en = diag_irq_enable;
    next_rdata = reg_rdata_o;
    if (reg_wr_i && hit_addr(reg_addr_i, `OFS_COMP_EDGE_UPPER)) begin
      next_comp_edge = reg_wdata_i;
    end
    if (reg_wr_i && hit_addr(reg_addr_i, `OFS_DIAG_ENABLE)) begin
      // Reserved bits never store, so they always read back zero
      next_diag_en = reg_wdata_i & `DIAG_WRITABLE_MASK;
    end
    if (reg_rd_i) begin
      if (hit_addr(reg_addr_i, `OFS_COMP_EDGE_UPPER)) begin
        next_rdata = comp_edge_irq_enable_upper;
      end else if (hit_addr(reg_addr_i, `OFS_DIAG_ENABLE)) begin
        next_rdata = diag_irq_enable & `DIAG_WRITABLE_MASK;
      end else begin
        // Other registers live elsewhere; answer zero here
        next_rdata = `REG_W'(0);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      comp_edge_irq_enable_upper <= `RST_COMP_EDGE_UPPER;
      diag_irq_enable <= `RST_DIAG_ENABLE;
      reg_rdata_o <= `REG_W'(0);
    end else begin
      comp_edge_irq_enable_upper <= next_comp_edge;
      diag_irq_enable <= next_diag_en;
      reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator edge detection, one detector per input

  logic [NUM_IN-1:0] edge_hit;

  // Field i sits at bits 2i+1..2i, input 12 lowest; group of four per
  // threshold is chosen upstream, the code is only the edge choice
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    edge_detect u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cmp_i(cmp_result_i[i]),
      .code_i(comp_edge_irq_enable_upper[`EDGE_FIELD_W*i +:
                                         `EDGE_FIELD_W]),
      .hit_o(edge_hit[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending comparator events: set beats clear

  logic [NUM_IN-1:0] next_pending;

  always_comb begin
    next_pending = (comp_pending_o & ~comp_pending_clr_i) | edge_hit;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      comp_pending_o <= '0;
    end else begin
      comp_pending_o <= next_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Diagnostic gating and interrupt pin

  logic diag_any;
  logic next_irq_n;

  // Bits 11..0 of the enable register pair with event bits 11..0
  diag_gate u_diag (
    .event_i(diag_event_i),
    .enable_i(diag_irq_enable[`DIAG_SRC_W-1:0]),
    .any_o(diag_any)
  );

  always_comb begin
    next_irq_n = ~(diag_any | (|comp_pending_o));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= next_irq_n;
    end
  end

endmodule

// ==== testbench/irq_mask_chk.sv ====
// Purpose: Port-level checks of the interrupt enable block
// Assumes: Comparator inputs stay low while reset is held
// Notes: Register contents are judged through read-back only
`timescale 1ns/1ps
`include "irq_defs.svh"
module irq_mask_chk
  import irq_pkg::*;
#(
  parameter int NUM_IN = 12
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic [23:0] reg_rdata_o,
  input wire logic [NUM_IN-1:0] cmp_result_i,
  input wire logic [11:0] diag_event_i,
  input wire logic [NUM_IN-1:0] comp_pending_clr_i,
  input wire logic [NUM_IN-1:0] comp_pending_o,
  input wire logic irq_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_diag;
    reg_wr_i && reg_addr_i == `OFS_DIAG_ENABLE;
  endsequence
  sequence rd_diag;
    reg_rd_i && reg_addr_i == `OFS_DIAG_ENABLE;
  endsequence
  // The host leaves one idle cycle after each write, so read-back follows
  // two edges after the write strobe
  a_diag_readback: assert property (wr_diag ##1 !reg_wr_i ##1 rd_diag |=>
    reg_rdata_o == ($past(reg_wdata_i, 3) & 24'h000fff))
    else $error("diag enable read-back wrong");
  a_rsvd_zero: assert property (rd_diag |=> reg_rdata_o[23:12] == 12'h000)
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i != 6'h23 &&
    reg_addr_i != 6'h24 |=> reg_rdata_o == 24'h000000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_pend_irq: assert property (|comp_pending_o |=> !irq_n_o)
    else $error("pending event without interrupt");
  a_irq_quiet: assert property (diag_event_i == 12'h000 &&
    comp_pending_o == '0 |=> irq_n_o)
    else $error("interrupt without source");
  a_pend_cause: assert property ((comp_pending_o & ~$past(comp_pending_o) &
    ~($past(cmp_result_i) ^ $past(cmp_result_i, 2))) == '0)
    else $error("pending set without edge");
  a_pend_sticky: assert property ((~comp_pending_o & $past(comp_pending_o) &
    ~$past(comp_pending_clr_i)) == '0)
    else $error("pending lost without clear");
  a_pend_clear: assert property (&comp_pending_clr_i &&
    $stable(cmp_result_i) |=> comp_pending_o == '0)
    else $error("pending not cleared");
endmodule
bind switch_irq_enable_mask irq_mask_chk #(.NUM_IN(NUM_IN)) chk_i (.*);

// ==== testbench/host_model.sv ====
// Purpose: Host side that programs the enable registers
// Assumes: Called just after a rising edge of clk_i
// Notes: Each access ends with an idle cycle so strobes never retoggle
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic [23:0] rdata_i,
  output logic [5:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [23:0] wdata_o
);
  initial begin
    addr_o = 6'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 24'h000000;
  end
  task automatic write(input logic [5:0] a, input logic [23:0] d);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1 wr_o = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic read(input logic [5:0] a, output logic [23:0] d);
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1 rd_o = 1'b0;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Register and interrupt tests of the enable block
// Assumes: Host model drives the register strobes
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_top;
  import irq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] cmp = 12'h000;
  logic [11:0] ev = 12'h000;
  logic [11:0] clr = 12'h000;
  logic [11:0] pend;
  logic [23:0] rdata;
  logic [23:0] d;
  logic [5:0] addr;
  logic wr;
  logic rd;
  logic [23:0] wdata;
  logic irq_n;
  int fail_count = 0;
  int n_checks = 0;
  always #50 clk_i = ~clk_i;
  host_model host_i (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  switch_irq_enable_mask switch_irq_enable_mask_i (.clk_i(clk_i),
    .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .cmp_result_i(cmp),
    .diag_event_i(ev), .comp_pending_clr_i(clr), .comp_pending_o(pend),
    .irq_n_o(irq_n));
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fail_count++;
    wrap_up();
  end
  initial begin
    step(6);
    rst_i = 1'b0;
    check(24'(irq_n), 24'h1);
    host_i.read(6'h23, d); check(d, 24'h0);
    host_i.read(6'h24, d); check(d, 24'h0);
    host_i.write(6'h24, 24'hffffff);
    host_i.read(6'h24, d); check(d, 24'h000fff);
    host_i.write(6'h25, 24'h123456);
    host_i.read(6'h25, d); check(d, 24'h0);
    $display("test registers done");
    for (int b = 0; b < 12; b++) begin
      ev = 12'h001 << b;
      host_i.write(6'h24, 24'hfff ^ (24'h1 << b));
      check(24'(irq_n), 24'h1);
      host_i.write(6'h24, 24'h1 << b);
      check(24'(irq_n), 24'h0);
    end
    ev = 12'h000;
    $display("test diagnostic mask done");
    for (int i = 0; i < 12; i++) begin
      for (int c = 0; c < 4; c++) begin
        host_i.write(6'h23, 24'(c) << (2 * i));
        host_i.read(6'h23, d); check(d, 24'(c) << (2 * i));
        cmp[i] = 1'b1;
        step(2);
        check(24'(pend), 24'(c[0]) << i);
        step(1);
        check(24'(irq_n), 24'(!c[0]));
        cmp[i] = 1'b0;
        step(2);
        check(24'(pend), 24'(c[0] | c[1]) << i);
        clr = 12'hfff;
        step(1);
        clr = 12'h000;
        step(1);
        check(24'(pend), 24'h0);
      end
    end
    $display("test comparator codes done");
    wrap_up();
  end
endmodule
